//--- include/pmic_i2c_pkg.sv
// Constants, carriers and state types of the two-wire register access target.
// Assumes one 10 MHz system clock; the serial pins arrive from outside its domain.
package pmic_i2c_pkg;

  localparam logic [7:0] WR_ADDR_BYTE  = 8'h50;
  localparam logic [7:0] RD_ADDR_BYTE  = 8'h51;
  localparam logic [7:0] REG_LAST      = 8'h12;
  localparam logic [7:0] REG_HOLD_ADDR = 8'h00;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [7:0] PTR_STEP      = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_OUT_BIT  = 4'h7;
  localparam logic [3:0] BIT_STEP      = 4'h1;
  localparam int         BYTE_MSB      = 7;
  localparam int         RW_BIT        = 0;

  localparam int CLK_FREQ_KHZ       = 10000;
  localparam int SCL_MAX_KHZ        = 400;
  localparam int SCL_MIN_PERIOD_CYC = (CLK_FREQ_KHZ + SCL_MAX_KHZ - 1) / SCL_MAX_KHZ;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } pins_s;

  localparam pins_s PINS_IDLE = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA,
    ST_WHOLD, ST_WDATA_ACK, ST_RLOAD, ST_RDATA, ST_RACK, ST_SKIP
  } tgt_state_e;

  typedef struct packed {
    tgt_state_e st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       rd_mode;
    logic       ignore;
    logic       mack;
    logic [7:0] ptr;
    logic       sda_oe_n;
    logic       scl_oe_n;
    logic       pin_lo;
    logic       wr_valid;
    reg_wr_s    wr;
  } tgt_s;

  localparam tgt_s TGT_RESET = '{
    st: ST_IDLE, bit_cnt: 4'h0, shift: 8'h00, rd_mode: 1'b0, ignore: 1'b0,
    mack: 1'b0, ptr: PTR_RESET, sda_oe_n: 1'b1, scl_oe_n: 1'b1, pin_lo: 1'b0,
    wr_valid: 1'b0, wr: 16'h0000
  };

endpackage

//--- core/pin_sync.sv
// Two-flop synchroniser for the serial pins plus one stage for edge and steady-level detect.
// Assumes the pins idle high; reset loads that level so no false edge follows reset.
`timescale 1ns/1ps
module pin_sync
  import pmic_i2c_pkg::*;
(
  input  wire logic  clk_i,      // System clock
  input  wire logic  sys_rst_i,  // Asynchronous reset, active high
  input  wire pins_s pins_i,     // Raw pin levels
  output pins_s      lvl_o,      // Synchronised levels
  output pins_s      rise_o,     // One-cycle rising edge pulses
  output pins_s      fall_o,     // One-cycle falling edge pulses
  output pins_s      steady_o    // High for two samples running
);

  typedef struct packed {
    pins_s meta;
    pins_s sync;
    pins_s prev;
  } sync_s;

  sync_s q_r;
  sync_s q_nxt;

  // Only the second stage reads the first one
  always_comb begin
    q_nxt      = q_r;
    q_nxt.meta = pins_i;
    q_nxt.sync = q_r.meta;
    q_nxt.prev = q_r.sync;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_r <= '{meta: PINS_IDLE, sync: PINS_IDLE, prev: PINS_IDLE};
    end else begin
      q_r <= q_nxt;
    end
  end

  // At 400 kHz an SCL period spans 25 samples, so three-cycle latency is harmless
  assign lvl_o    = q_r.sync;
  assign rise_o   = q_r.sync & ~q_r.prev;
  assign fall_o   = ~q_r.sync & q_r.prev;
  assign steady_o = q_r.sync & q_r.prev;

endmodule

//--- core/stream_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; width and depth come from the instantiating module.
`timescale 1ns/1ps
module stream_fifo
  import pmic_i2c_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_i,        // System clock
  input  wire logic             sys_rst_i,    // Asynchronous reset, active high
  input  wire logic             in_valid_i,   // Write side offers a word
  output logic                  in_ready_o,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data_i,    // Word to store
  output logic                  out_valid_o,  // A word is available
  input  wire logic             out_ready_i,  // Read side takes the word
  output logic      [WIDTH-1:0] out_data_o    // Oldest word
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
  } fifo_s;

  fifo_s            q_r;
  fifo_s            q_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_o  = (q_r.count != CW'(DEPTH));
  assign out_valid_o = (q_r.count != '0);
  assign out_data_o  = mem[q_r.rptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.wptr = (q_r.wptr == AW'(DEPTH - 1)) ? '0 : q_r.wptr + 1'b1;
    end
    if (pop) begin
      q_nxt.rptr = (q_r.rptr == AW'(DEPTH - 1)) ? '0 : q_r.rptr + 1'b1;
    end
    if (push && !pop) begin
      q_nxt.count = q_r.count + 1'b1;
    end else if (pop && !push) begin
      q_nxt.count = q_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Storage needs no reset; a word is only read after it was written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[q_r.wptr] <= in_data_i;
    end
  end

endmodule

//--- core/pmic_i2c_register_access.sv
// Two-wire serial target giving a host access to the 8-bit register bank.
// Assumes the register bank reads combinationally from rd_addr_o and takes
// writes by valid/ready; the serial pins are open-drain with external pull-ups.
`timescale 1ns/1ps
// Function
// - Answer only address bytes 0x50 and 0x51
// - Work with serial clock up to 400kHz
// - First byte is address; low bit picks direction
// - Sample one data bit per clock rise
// - Data change while clock high is start/stop
// - Both lines released high when idle
// - Acknowledge register address only when valid
// - Acknowledge own address byte when it matches
// - Acknowledge every written data byte
// - Pointer steps after each written data byte or acknowledged read byte, holds at 0x00
// - Shift out addressed register, eight bits MSB first
// - Keep sending bytes until host not-acknowledges
// - Acknowledge holds data low through ninth clock
module pmic_i2c_register_access
  import pmic_i2c_pkg::*;
(
  input  wire logic       clk_i,       // System clock, 10 MHz
  input  wire logic       sys_rst_i,   // Asynchronous reset, active high
  input  wire logic       scl_i,       // Serial clock pin level
  output logic            scl_o,       // Serial clock drive level, always low
  output logic            scl_oe_n_o,  // Low while stretching the clock
  input  wire logic       sda_i,       // Serial data pin level
  output logic            sda_o,       // Serial data drive level, always low
  output logic            sda_oe_n_o,  // Low while pulling data low
  output logic            wr_valid_o,  // Register write offered
  input  wire logic       wr_ready_i,  // Register bank takes the write
  output reg_wr_s         wr_o,        // Register write address and data
  output logic      [7:0] rd_addr_o,   // Register read address
  input  wire logic [7:0] rd_data_i    // Register read data, same cycle
);

  tgt_s    q;
  tgt_s    n;
  pins_s   lvl;
  pins_s   rise;
  pins_s   fall;
  pins_s   steady;
  logic    start_ev;
  logic    stop_ev;
  logic    scl_rise;
  logic    scl_fall;
  logic    addr_hit;
  logic    drained;
  logic    fifo_push;
  logic    fifo_pop;
  logic    fifo_in_ready;
  logic    fifo_out_valid;
  reg_wr_s fifo_out;
  logic    [7:0] ptr_step;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  pin_sync u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pins_i    ('{scl: scl_i, sda: sda_i}),
    .lvl_o     (lvl),
    .rise_o    (rise),
    .fall_o    (fall),
    .steady_o  (steady)
  );

  // Writes queue here so a slow register bank stretches the clock instead of losing data
  stream_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({q.ptr, q.shift}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );

  assign start_ev = fall.sda && steady.scl;
  assign stop_ev  = rise.sda && steady.scl;
  assign scl_rise = rise.scl;
  assign scl_fall = fall.scl;
  assign addr_hit = (q.shift == WR_ADDR_BYTE) || (q.shift == RD_ADDR_BYTE);
  assign ptr_step = (q.ptr == REG_HOLD_ADDR) ? q.ptr : q.ptr + PTR_STEP;
  assign drained  = !fifo_out_valid && !q.wr_valid;
  assign fifo_pop = fifo_out_valid && (!q.wr_valid || wr_ready_i);

  always_comb begin
    n         = q;
    fifo_push = 1'b0;
    if (wr_ready_i) begin
      n.wr_valid = 1'b0;
    end
    if (fifo_pop) begin
      n.wr_valid = 1'b1;
      n.wr       = fifo_out;
    end
    if (stop_ev) begin
      n.st       = ST_IDLE;
      n.sda_oe_n = 1'b1;
      n.scl_oe_n = 1'b1;
      n.ignore   = 1'b0;
    end else if (start_ev) begin
      // Repeated start keeps the pointer for the read that follows
      n.st       = ST_ADDR;
      n.bit_cnt  = 4'h0;
      n.sda_oe_n = 1'b1;
      n.scl_oe_n = 1'b1;
      n.ignore   = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE, ST_SKIP: begin
          n.sda_oe_n = 1'b1;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise) begin
            n.shift   = {q.shift[BYTE_MSB-1:0], lvl.sda};
            n.bit_cnt = q.bit_cnt + BIT_STEP;
          end else if (scl_fall && q.bit_cnt == BITS_PER_BYTE) begin
            n.bit_cnt = 4'h0;
            if (q.st == ST_ADDR) begin
              if (addr_hit) begin
                n.rd_mode  = q.shift[RW_BIT];
                n.sda_oe_n = 1'b0;
                n.st       = ST_ADDR_ACK;
              end else begin
                n.st = ST_SKIP;
              end
            end else if (q.st == ST_REG) begin
              n.ptr      = q.shift;
              n.ignore   = (q.shift > REG_LAST);
              n.sda_oe_n = (q.shift > REG_LAST);
              n.st       = ST_REG_ACK;
            end else if (q.ignore) begin
              n.sda_oe_n = 1'b0;
              n.st       = ST_WDATA_ACK;
            end else if (fifo_in_ready) begin
              fifo_push  = 1'b1;
              n.sda_oe_n = 1'b0;
              n.st       = ST_WDATA_ACK;
            end else begin
              n.scl_oe_n = 1'b0;
              n.st       = ST_WHOLD;
            end
          end
        end
        ST_WHOLD: begin
          // Acknowledge is set up a cycle before the clock is let go
          if (!q.sda_oe_n) begin
            n.scl_oe_n = 1'b1;
            n.st       = ST_WDATA_ACK;
          end else if (fifo_in_ready) begin
            fifo_push  = 1'b1;
            n.sda_oe_n = 1'b0;
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            n.sda_oe_n = 1'b1;
            if (q.st == ST_ADDR_ACK && q.rd_mode) begin
              n.scl_oe_n = 1'b0;
              n.st       = ST_RLOAD;
            end else if (q.st == ST_ADDR_ACK) begin
              n.st = ST_REG;
            end else begin
              n.st = ST_WDATA;
              if (q.st == ST_WDATA_ACK) begin
                n.ptr = ptr_step;
              end
            end
          end
        end
        ST_RLOAD: begin
          // Pending writes drain first so a read never returns stale contents
          if (drained) begin
            n.shift    = rd_data_i;
            n.sda_oe_n = rd_data_i[BYTE_MSB];
            n.scl_oe_n = 1'b1;
            n.bit_cnt  = 4'h0;
            n.st       = ST_RDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (q.bit_cnt == LAST_OUT_BIT) begin
              n.sda_oe_n = 1'b1;
              n.bit_cnt  = 4'h0;
              n.st       = ST_RACK;
            end else begin
              n.shift    = q.shift << 1;
              n.sda_oe_n = q.shift[BYTE_MSB-1];
              n.bit_cnt  = q.bit_cnt + BIT_STEP;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            n.mack = !lvl.sda;
          end else if (scl_fall) begin
            if (q.mack) begin
              n.ptr      = ptr_step;
              n.scl_oe_n = 1'b0;
              n.st       = ST_RLOAD;
            end else begin
              n.st = ST_SKIP;
            end
          end
        end
        default: begin
          n = TGT_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= TGT_RESET;
    end else begin
      q <= n;
    end
  end

  assign scl_o      = q.pin_lo;
  assign sda_o      = q.pin_lo;
  assign scl_oe_n_o = q.scl_oe_n;
  assign sda_oe_n_o = q.sda_oe_n;
  assign wr_valid_o = q.wr_valid;
  assign wr_o       = q.wr;
  assign rd_addr_o  = q.ptr;

  sequence byte_in_done;
    scl_fall && q.bit_cnt == BITS_PER_BYTE && !start_ev && !stop_ev;
  endsequence

  sequence read_loaded;
    q.st == ST_RLOAD && drained && !start_ev && !stop_ev;
  endsequence

  sequence master_acked;
    q.st == ST_RACK && scl_fall && q.mack && !start_ev && !stop_ev;
  endsequence

  own_addr_ack_a: assert property ((q.st == ST_ADDR) and byte_in_done and addr_hit
    |=> q.st == ST_ADDR_ACK && !q.sda_oe_n)
    else $error("matching address byte not acknowledged");
  foreign_addr_a: assert property ((q.st == ST_ADDR) and byte_in_done and !addr_hit
    |=> q.st == ST_SKIP && q.sda_oe_n ##1 q.sda_oe_n)
    else $error("foreign address byte answered");
  reg_addr_ack_a: assert property ((q.st == ST_REG) and byte_in_done
    |=> q.sda_oe_n == ($past(q.shift) > REG_LAST) && q.ignore == q.sda_oe_n)
    else $error("register address acknowledge wrong");
  data_ack_a: assert property ((q.st == ST_WDATA) and byte_in_done and q.ignore
    |=> q.st == ST_WDATA_ACK && !q.sda_oe_n)
    else $error("data byte not acknowledged");
  ignore_store_a: assert property (q.ignore && q.st inside {ST_WDATA, ST_WDATA_ACK}
    |-> !fifo_push)
    else $error("byte stored after invalid register address");
  ptr_step_a: assert property (q.st == ST_WDATA_ACK && scl_fall && !start_ev && !stop_ev
    |=> q.ptr == (($past(q.ptr) == REG_HOLD_ADDR) ? REG_HOLD_ADDR : $past(q.ptr) + PTR_STEP))
    else $error("register pointer step wrong");
  start_cond_a: assert property (start_ev && !stop_ev
    |=> q.st == ST_ADDR && q.bit_cnt == 4'h0 && q.sda_oe_n)
    else $error("start condition not taken");
  stop_release_a: assert property (stop_ev
    |=> q.st == ST_IDLE && q.sda_oe_n && q.scl_oe_n)
    else $error("lines not released after stop");
  dir_select_a: assert property (q.st == ST_ADDR_ACK && scl_fall && !start_ev && !stop_ev
    |=> q.st == ($past(q.rd_mode) ? ST_RLOAD : ST_REG))
    else $error("direction bit ignored");
  msb_first_a: assert property (read_loaded
    |=> q.st == ST_RDATA && q.sda_oe_n == $past(rd_data_i[BYTE_MSB]) && q.scl_oe_n)
    else $error("read byte does not start with its top bit");
  byte_release_a: assert property (q.st == ST_RDATA && scl_fall && q.bit_cnt == LAST_OUT_BIT
    && !start_ev && !stop_ev |=> q.st == ST_RACK && q.sda_oe_n)
    else $error("data line held after sent byte");
  burst_read_a: assert property (master_acked
    |=> q.st == ST_RLOAD && !q.scl_oe_n)
    else $error("burst read not continued");
  sample_rise_a: assert property (q.st == ST_REG && scl_rise && !start_ev && !stop_ev
    |=> q.shift[0] == $past(lvl.sda) && q.bit_cnt == $past(q.bit_cnt) + BIT_STEP)
    else $error("bit not sampled on clock rise");
  ack_hold_a: assert property (q.st == ST_ADDR_ACK && !scl_fall && !start_ev && !stop_ev
    |=> !q.sda_oe_n)
    else $error("acknowledge released before ninth clock ends");

endmodule

//--- tb/host_model.sv
// Two-wire bus controller that talks to the register access target.
// Assumes the bench resolves both wires from all pulls with pull-ups; clk_i paces the bits.
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_i,       // Pacing clock
  input  wire logic scl_i,       // Resolved clock wire
  input  wire logic sda_i,       // Resolved data wire
  output logic      scl_pull_o,  // High pulls the clock wire low
  output logic      sda_pull_o,  // High pulls the data wire low
  output logic      hang_o       // Clock wire held low too long
);
  // Idle with both wires released; the clock stands still between frames
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    hang_o     = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // The target may stretch the clock, so wait, but not forever
  task automatic clk_high();
    int i;
    scl_pull_o = 1'b0;
    for (i = 0; i < 5000 && scl_i !== 1'b1; i++)
      tick(1);
    if (i == 5000)
      hang_o = 1'b1;
  endtask

  // Eight cycles a bit gives 800 ns, shorter than the 25-cycle period of the 400 kHz clock limit
  task automatic xfer_bit(input logic b, output logic s);
    sda_pull_o = ~b;
    tick(2);
    clk_high();
    tick(2);
    s = sda_i;
    tick(2);
    scl_pull_o = 1'b1;
    tick(2);
  endtask

  // Also serves as repeated start when the clock is low
  task automatic start();
    sda_pull_o = 1'b0;
    tick(2);
    clk_high();
    tick(2);
    sda_pull_o = 1'b1;
    tick(2);
    scl_pull_o = 1'b1;
    tick(2);
  endtask

  task automatic stop();
    sda_pull_o = 1'b1;
    tick(2);
    clk_high();
    tick(2);
    sda_pull_o = 1'b0;
    tick(4);
  endtask

  task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], q[i]);
    xfer_bit(ack_in, ack);
  endtask
endmodule

//--- tb/pmic_i2c_register_access_test.sv
// Self-checking bench of the two-wire register access target.
// Assumes host_model as bus controller and a combinational register bank modelled here.
`timescale 1ns/1ps
module pmic_i2c_register_access_test;
  import pmic_i2c_pkg::*;
  typedef struct {
    logic [7:0] r;
    logic [7:0] d;
    logic       nack;
  } row_s;
  logic       clk_i;
  logic       sys_rst_i;
  logic       scl_w;
  logic       sda_w;
  logic       scl_pull;
  logic       sda_pull;
  logic       hang;
  logic       scl_o;
  logic       scl_oe_n_o;
  logic       sda_o;
  logic       sda_oe_n_o;
  logic       wr_valid_o;
  logic       wr_ready_i;
  reg_wr_s    wr_o;
  logic [7:0] rd_addr_o;
  logic [7:0] rd_data_i;
  logic [7:0] mem [256];
  logic [7:0] exp_mem [256];
  logic       stretch_seen;
  logic       a;
  logic [7:0] q;
  int         n_wr;
  int         miscompares;
  int         n_tests;
  logic [7:0] bad [2] = '{8'h52, 8'hd0};
  row_s rows [5] = '{'{8'h02, 8'ha5, 1'b0}, '{8'h12, 8'h3c, 1'b0}, '{8'h00, 8'h81, 1'b0},
                     '{8'h13, 8'h77, 1'b1}, '{8'hff, 8'h12, 1'b1}};

  // The target's drive level counts when enabled, so a wrong level shows on the wire
  assign scl_w     = (scl_oe_n_o | scl_o) & ~scl_pull;
  assign sda_w     = (sda_oe_n_o | sda_o) & ~sda_pull;
  assign rd_data_i = mem[rd_addr_o];

  pmic_i2c_register_access u_pmic_i2c_register_access (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_o(wr_o),
    .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i));

  host_model u_host_model (
    .clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_pull_o(scl_pull),
    .sda_pull_o(sda_pull), .hang_o(hang));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
      mem[wr_o.addr] = wr_o.data;
      n_wr++;
    end
    if (scl_oe_n_o === 1'b0)
      stretch_seen = 1'b1;
  end

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic [7:0] dummy;
    u_host_model.xfer_byte(d, 1'b1, dummy, ack);
  endtask

  // Bank writes land a few cycles after the frame, so poll with a bound
  task automatic wait_writes(input int want);
    for (int i = 0; i < 3000 && n_wr < want; i++)
      @(posedge clk_i);
    #1;
    if (n_wr < want) begin
      miscompares++;
      $display("mismatch at %0t: bank writes missing", $time);
      stop_test();
    end
  endtask

  task automatic write_burst(input logic [7:0] r, input int n, input logic [7:0] d0,
                             input logic nack);
    logic [7:0] p;
    int want;
    want = n_wr + (nack ? 0 : n);
    p = r;
    u_host_model.start();
    send(WR_ADDR_BYTE, a);
    check_bit(a, 1'b0, "write address ack");
    send(r, a);
    check_bit(a, nack, "register address ack");
    for (int i = 0; i < n; i++) begin
      send(d0 + 8'(i), a);
      check_bit(a, 1'b0, "data ack");
      if (!nack)
        exp_mem[p] = d0 + 8'(i);
      p = (p == REG_HOLD_ADDR) ? p : p + PTR_STEP;
    end
    u_host_model.stop();
    wait_writes(want);
    for (int k = 0; k < 22; k++)
      check_byte(mem[k], exp_mem[k], "bank contents");
  endtask

  task automatic read_burst(input logic [7:0] r, input int n);
    logic [7:0] p;
    u_host_model.start();
    send(WR_ADDR_BYTE, a);
    send(r, a);
    u_host_model.start();
    send(RD_ADDR_BYTE, a);
    check_bit(a, 1'b0, "read address ack");
    p = r;
    for (int i = 0; i < n; i++) begin
      u_host_model.xfer_byte(8'hff, i == n - 1, q, a);
      check_byte(q, exp_mem[p], "read data");
      p = (p == REG_HOLD_ADDR) ? p : p + PTR_STEP;
    end
    check_bit(a, 1'b1, "data line released");
    u_host_model.stop();
  endtask

  always @(posedge hang) begin
    miscompares++;
    $display("mismatch at %0t: clock held low", $time);
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    $display("mismatch at %0t: run too long", $time);
    stop_test();
  end

  initial begin
    sys_rst_i    = 1'b1;
    wr_ready_i   = 1'b1;
    stretch_seen = 1'b0;
    n_wr         = 0;
    miscompares  = 0;
    n_tests      = 0;
    for (int k = 0; k < 256; k++) begin
      mem[k]     = 8'(k) ^ 8'h5a;
      exp_mem[k] = 8'(k) ^ 8'h5a;
    end
    repeat (8) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    check_bit(scl_w & sda_w, 1'b1, "idle wires");
    check_bit(wr_valid_o, 1'b0, "no write after reset");
    check_byte(rd_addr_o, PTR_RESET, "pointer after reset");
    $display("test reset finished");
    foreach (rows[i]) begin
      write_burst(rows[i].r, 1, rows[i].d, rows[i].nack);
      if (!rows[i].nack)
        read_burst(rows[i].r, 1);
    end
    $display("test table finished");
    foreach (bad[i]) begin
      u_host_model.start();
      send(bad[i], a);
      check_bit(a, 1'b1, "foreign address");
      u_host_model.stop();
    end
    $display("test foreign address finished");
    // A stop inside a byte must abort it, not complete it
    u_host_model.start();
    send(WR_ADDR_BYTE, a);
    send(8'h05, a);
    for (int k = 0; k < 3; k++)
      u_host_model.xfer_bit(1'b0, a);
    u_host_model.stop();
    read_burst(8'h05, 1);
    $display("test stop in byte finished");
    write_burst(8'h00, 3, 8'h90, 1'b0);
    read_burst(8'h00, 2);
    read_burst(8'h10, 3);
    $display("test bursts finished");
    // Bank stalls: FIFO fills and the target must hold the clock
    stretch_seen = 1'b0;
    wr_ready_i   = 1'b0;
    fork
      begin
        repeat (2000) @(posedge clk_i);
        #1;
        wr_ready_i = 1'b1;
      end
    join_none
    write_burst(8'h01, 20, 8'h40, 1'b0);
    check_bit(stretch_seen, 1'b1, "clock stretched when full");
    repeat (4) @(posedge clk_i);
    #1;
    check_bit(wr_valid_o, 1'b0, "drained");
    $display("test full buffer finished");
    stop_test();
  end
endmodule
